// ---- hw/tps_host.sv ----
// Purpose: Host sequencer that brings the codec up without pops.
// Assumes: Device control port on the same clock.
// Notes: Settle waits are counted here; the device times only its power-on reset hold.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`include "tps_map.svh"
module tps_host #(
  parameter int WAIT_REG_CYC = `TPS_WAIT_REG_CYC,
  parameter int WAIT_MID_CYC = `TPS_WAIT_MID_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  tps_ctrl_if.host bus,
  input wire logic [3:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [15:0] sw_rdata
);
  import tps_pkg::*;

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  logic mid_ref_reg;
  logic line_en_reg;
  logic spk_en_reg;
  logic done_reg;
  tps_state_t state_reg;
  tps_state_t state_next;
  wire busy = state_reg != TPS_IDLE && state_reg != TPS_DONE;
  wire wr_ctrl = sw_wr && sw_addr == `TPS_SW_CTRL;
  wire start = wr_ctrl && sw_wdata[`TPS_B_START] && !busy;

  // Options are frozen while a sequence runs so steps stay consistent.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mid_ref_reg <= 1'b0;
      line_en_reg <= 1'b0;
      spk_en_reg <= 1'b0;
    end else if (wr_ctrl && !busy) begin
      mid_ref_reg <= sw_wdata[`TPS_B_MID_REF];
      line_en_reg <= sw_wdata[`TPS_B_LINE_EN];
      spk_en_reg <= sw_wdata[`TPS_B_SPK_EN];
    end
  end

  logic [15:0] rd_mux;
  wire [15:0] ctrl_view = {12'h000, spk_en_reg, line_en_reg,
    mid_ref_reg, 1'b0};
  wire [15:0] status_view = {13'h0, bus.por_n, done_reg, busy};
  always_comb begin
    unique case (sw_addr)
      `TPS_SW_CTRL: rd_mux = ctrl_view;
      `TPS_SW_STATUS: rd_mux = status_view;
      default: rd_mux = 16'h0000;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sw_rdata <= 16'h0000;
    else if (sw_rd) sw_rdata <= rd_mux;
    else sw_rdata <= 16'h0000;
  end

  // ----------------------------------------
  // Step table
  // ----------------------------------------
  logic [3:0] step_reg;
  logic [7:0] step_addr;
  logic [15:0] step_data;
  logic [1:0] step_wait;
  wire [15:0] reg_sel = mid_ref_reg ? `TPS_REG_FAST_REF : 16'h0000;
  wire [15:0] out_base = `TPS_OUT_CTRL_RST | `TPS_MIDCON_BITS;
  wire [15:0] pwr2_outs = `TPS_PWR2_MIXDAC
    | (spk_en_reg ? `TPS_PWR2_SPK : 16'h0000)
    | (line_en_reg ? `TPS_PWR2_LINE : 16'h0000);
  wire [15:0] drive = spk_en_reg ? `TPS_PWR2_DRIVE : 16'h0000;
  wire [15:0] ref_on = `TPS_REF_START | `TPS_REF_MID_ON;

  // Wait codes: 0 none, 1 regulator settle, 2 midrail settle.
  always_comb begin
    step_addr = `TPS_A_SOFT_RESET;
    step_data = 16'h0000;
    step_wait = 2'd0;
    unique case (step_reg)
      4'd0: begin
        step_addr = `TPS_A_SOFT_RESET;
      end
      4'd1: begin
        step_addr = `TPS_A_OUT_CTRL;
        step_data = `TPS_OUT_CTRL_RST | `TPS_DISCH_BITS;
      end
      4'd2: begin
        step_addr = `TPS_A_OUT_CTRL;
        step_data = out_base | `TPS_DISCH_BITS;
      end
      4'd3: begin
        step_addr = `TPS_A_REF;
        step_data = `TPS_REF_START;
      end
      4'd4: begin
        step_addr = `TPS_A_REG_CTRL;
        step_data = reg_sel | `TPS_REG_BIAS | `TPS_REG_ON;
        step_wait = 2'd1;
      end
      4'd5: begin
        step_addr = `TPS_A_PWR1;
        step_data = `TPS_PWR1_FAST;
      end
      4'd6: begin
        step_addr = `TPS_A_OUT_CTRL;
        step_data = out_base;
      end
      4'd7: begin
        step_addr = `TPS_A_PWR2;
        step_data = `TPS_PWR2_MIXDAC;
      end
      4'd8: begin
        step_addr = `TPS_A_PWR2;
        step_data = pwr2_outs;
      end
      4'd9: begin
        step_addr = `TPS_A_PWR2;
        step_data = pwr2_outs | drive;
      end
      4'd10: begin
        step_addr = `TPS_A_REF;
        step_data = ref_on;
        step_wait = 2'd2;
      end
      4'd11: begin
        step_addr = `TPS_A_REG_CTRL;
        step_data = reg_sel & ~`TPS_REG_FAST_REF | `TPS_REG_ON;
      end
      4'd12: begin
        step_addr = `TPS_A_REF;
        step_data = ref_on & ~`TPS_REF_FAST_BITS;
      end
      4'd13: begin
        step_addr = `TPS_A_PWR1;
        step_data = `TPS_PWR1_NORMAL;
      end
      default: begin
        step_addr = `TPS_A_SOFT_RESET;
      end
    endcase
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  logic [24:0] wait_reg;
  logic [1:0] wait_kind_reg;
  wire last = step_reg == `TPS_LAST_STEP;
  wire [24:0] wait_len = wait_kind_reg == 2'd1 ?
    25'(WAIT_REG_CYC - 1) : 25'(WAIT_MID_CYC - 1);
  wire wait_end = wait_reg == wait_len;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      TPS_IDLE: if (start) state_next = TPS_WAIT_POR;
      TPS_WAIT_POR: if (bus.por_n) state_next = TPS_WRITE;
      TPS_WRITE: begin
        if (!bus.por_n) state_next = TPS_WAIT_POR;
        else if (step_wait != 2'd0) state_next = TPS_DELAY;
        else if (last) state_next = TPS_DONE;
      end
      TPS_DELAY: begin
        if (!bus.por_n) state_next = TPS_WAIT_POR;
        else if (wait_end) state_next = TPS_WRITE;
      end
      TPS_DONE: if (start) state_next = TPS_WAIT_POR;
      default: state_next = TPS_IDLE;
    endcase
  end

  // A device reset mid-sequence restarts from the soft reset step,
  // because every earlier write has been wiped.
  wire restart = state_reg != TPS_IDLE && state_reg != TPS_DONE
    && !bus.por_n;
  wire issue = state_reg == TPS_WRITE && bus.por_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= TPS_IDLE;
      step_reg <= 4'h0;
      wait_reg <= 25'h0000000;
      wait_kind_reg <= 2'd0;
    end else begin
      state_reg <= state_next;
      if (start || restart) step_reg <= 4'h0;
      else if (issue && !last) step_reg <= step_reg + 4'h1;
      else if (state_reg == TPS_DELAY && wait_end) step_reg <= step_reg;
      if (issue) begin
        wait_kind_reg <= step_wait;
        wait_reg <= 25'h0000000;
      end else if (state_reg == TPS_DELAY) begin
        wait_reg <= wait_reg + 25'h0000001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) done_reg <= 1'b0;
    else if (issue && last) done_reg <= 1'b1;
    else if (start) done_reg <= 1'b0;
  end

  // ----------------------------------------
  // Control port drive
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      bus.addr <= 8'h00;
      bus.wdata <= 16'h0000;
    end else begin
      bus.wr <= issue;
      bus.rd <= 1'b0;
      bus.addr <= issue ? step_addr : 8'h00;
      bus.wdata <= issue ? step_data : 16'h0000;
    end
  end
endmodule

// ---- shared/tps_map.svh ----
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: 100 MHz clock on both ends.
// Notes: Device offsets are register indexes on the control port.
//
// Operation
// - Thermal status flag readable, 1 means overtemperature.
// - Flag polled, sent to pin, or raises events.
// - Shutdown enable resets to 1, kills speakers.
// - Internal reset low while either supply low.
// - Writes ignored while internal reset low.
// - Release with defaults, then accept writes.
// - Reset held at least minimum period.
// - Reset reasserts when either supply drops.
// - Separate resets for I/O and speaker supplies.
// - Host first writes soft reset word.
// - Host sets speaker and line discharge bits.
// - Host connects midrail to speaker and line.
// - Host sets fast start, bias, ramp 01.
// - Host programs regulator, enables it, waits 300 ms.
// - Host enables bias, buffer, divider select 11.
// - Host clears the discharge bits.
// - Host enables speaker mixers and converters.
// - Host enables needed outputs and stages.
// - Supply drive only after output stages.
// - Host sets midrail on, waits 150 ms.
// - Host restores normal bias, divider 01.
// - Stage before drive up, drive first down.
`ifndef TPS_MAP_SVH
`define TPS_MAP_SVH

`define TPS_CLK_NS 10
`define TPS_TPOR_NS 10600
`define TPS_TPOR_CYC ((`TPS_TPOR_NS + `TPS_CLK_NS - 1) / `TPS_CLK_NS)
`define TPS_WAIT_REG_MS 300
`define TPS_WAIT_MID_MS 150
`define TPS_WAIT_REG_CYC (`TPS_WAIT_REG_MS * 1000000 / `TPS_CLK_NS)
`define TPS_WAIT_MID_CYC (`TPS_WAIT_MID_MS * 1000000 / `TPS_CLK_NS)

`define TPS_A_SOFT_RESET 8'h00
`define TPS_A_PWR1 8'h02
`define TPS_A_PWR2 8'h03
`define TPS_A_REF 8'h07
`define TPS_A_STATUS 8'h11
`define TPS_A_OUT_CTRL 8'h2a
`define TPS_A_REG_CTRL 8'h35

`define TPS_OUT_CTRL_RST 16'h8000
`define TPS_B_THERMAL_STATUS_FLAG 15
`define TPS_B_SHUTDOWN_EN 15
`define TPS_B_R_STAGE 7
`define TPS_B_L_STAGE 6
`define TPS_B_R_DRIVE 11
`define TPS_B_L_DRIVE 10

`define TPS_DISCH_BITS 16'h00d0
`define TPS_MIDCON_BITS 16'h3400
`define TPS_REF_START 16'h09a0
`define TPS_REF_MID_ON 16'h0010
`define TPS_REF_FAST_BITS 16'h0900
`define TPS_REG_FAST_REF 16'h4000
`define TPS_REG_BIAS 16'h0020
`define TPS_REG_ON 16'h8000
`define TPS_PWR1_FAST 16'h000f
`define TPS_PWR1_NORMAL 16'h000d
`define TPS_PWR2_MIXDAC 16'h000f
`define TPS_PWR2_SPK 16'h30c0
`define TPS_PWR2_LINE 16'hc000
`define TPS_PWR2_DRIVE 16'h0c00

`define TPS_SW_CTRL 4'h0
`define TPS_SW_STATUS 4'h1
`define TPS_B_START 0
`define TPS_B_MID_REF 1
`define TPS_B_LINE_EN 2
`define TPS_B_SPK_EN 3
`define TPS_LAST_STEP 4'd13

`endif

// ---- shared/tps_pkg.sv ----
// Purpose: Types shared by both ends.
// Assumes: Constants live in the map header.
// Notes: Host states are Gray coded along the usual path.
package tps_pkg;
  typedef logic [7:0] tps_addr_t;
  typedef logic [15:0] tps_word_t;
  typedef enum logic [2:0] {
    TPS_IDLE = 3'b000,
    TPS_WAIT_POR = 3'b001,
    TPS_WRITE = 3'b011,
    TPS_DELAY = 3'b010,
    TPS_DONE = 3'b111
  } tps_state_t;
endpackage

// ---- shared/tps_ctrl_if.sv ----
// Purpose: Control port between the host sequencer and the device.
// Assumes: One clock shared by both ends.
// Notes: Read data stand in the cycle after the read strobe.
`timescale 1ns/10ps
interface tps_ctrl_if (
  input wire logic clk
);
  import tps_pkg::*;
  logic wr;
  logic rd;
  tps_addr_t addr;
  tps_word_t wdata;
  tps_word_t rdata;
  logic por_n;

  modport dev (input clk, input wr, input rd, input addr, input wdata,
    output rdata, output por_n);
  modport host (input clk, output wr, output rd, output addr,
    output wdata, input rdata, input por_n);
endinterface

// ---- hw/tps_device.sv ----
// Purpose: Codec power-on reset, register file and thermal shutdown.
// Assumes: Supply-good and sensor inputs are asynchronous comparators.
// Notes: Register words drive the analogue blocks directly.
`timescale 1ns/10ps
`include "tps_map.svh"
module tps_device (
  input wire logic rst_n,
  tps_ctrl_if.dev bus,
  input wire logic regulator_supply_ok,
  input wire logic core_supply_ok,
  input wire logic digital_io_supply_ok,
  input wire logic speaker_supply_ok,
  input wire logic overtemp,
  output tps_pkg::tps_word_t pwr1_word,
  output tps_pkg::tps_word_t pwr2_word,
  output tps_pkg::tps_word_t ref_word,
  output tps_pkg::tps_word_t reg_ctrl_word,
  output tps_pkg::tps_word_t out_ctrl_word,
  output logic spk_r_on,
  output logic spk_l_on,
  output logic thermal_gpio,
  output logic thermal_event,
  output logic io_por_n,
  output logic spk_por_n
);
  import tps_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [4:0] in_meta_reg;
  logic [4:0] in_sync_reg;
  logic [4:0] in_raw;
  assign in_raw = {overtemp, speaker_supply_ok, digital_io_supply_ok,
    core_supply_ok, regulator_supply_ok};
  always_ff @(posedge bus.clk or negedge rst_n) begin
    if (!rst_n) begin
      in_meta_reg <= 5'h00;
      in_sync_reg <= 5'h00;
    end else begin
      in_meta_reg <= in_raw;
      in_sync_reg <= in_meta_reg;
    end
  end
  wire supplies_ok = in_sync_reg[0] & in_sync_reg[1];
  wire thermal_status_flag = in_sync_reg[4];

  // ----------------------------------------
  // Power-on reset
  // ----------------------------------------
  localparam int POR_CYC = `TPS_TPOR_CYC;
  logic [10:0] por_cnt_reg;
  logic por_n_reg;
  wire por_done = por_cnt_reg == 11'(POR_CYC - 1);
  always_ff @(posedge bus.clk or negedge rst_n) begin
    if (!rst_n) begin
      por_cnt_reg <= 11'h000;
      por_n_reg <= 1'b0;
    end else if (!supplies_ok) begin
      por_cnt_reg <= 11'h000;
      por_n_reg <= 1'b0;
    end else if (!por_n_reg) begin
      por_cnt_reg <= por_done ? por_cnt_reg : por_cnt_reg + 11'h001;
      por_n_reg <= por_done;
    end
  end
  assign bus.por_n = por_n_reg;

  always_ff @(posedge bus.clk or negedge rst_n) begin
    if (!rst_n) begin
      io_por_n <= 1'b0;
      spk_por_n <= 1'b0;
    end else begin
      io_por_n <= in_sync_reg[2];
      spk_por_n <= in_sync_reg[3];
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  // writes dropped in reset
  wire wr_ok = bus.wr & por_n_reg;
  wire clear = !por_n_reg | (wr_ok & bus.addr == `TPS_A_SOFT_RESET);
  wire wr_pwr1 = wr_ok & bus.addr == `TPS_A_PWR1;
  wire wr_pwr2 = wr_ok & bus.addr == `TPS_A_PWR2;
  wire wr_ref = wr_ok & bus.addr == `TPS_A_REF;
  wire wr_regc = wr_ok & bus.addr == `TPS_A_REG_CTRL;
  wire wr_out = wr_ok & bus.addr == `TPS_A_OUT_CTRL;
  always_ff @(posedge bus.clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr1_word <= 16'h0000;
      pwr2_word <= 16'h0000;
      ref_word <= 16'h0000;
      reg_ctrl_word <= 16'h0000;
      out_ctrl_word <= `TPS_OUT_CTRL_RST;
    end else if (clear) begin
      pwr1_word <= 16'h0000;
      pwr2_word <= 16'h0000;
      ref_word <= 16'h0000;
      reg_ctrl_word <= 16'h0000;
      out_ctrl_word <= `TPS_OUT_CTRL_RST;
    end else begin
      if (wr_pwr1) pwr1_word <= bus.wdata;
      if (wr_pwr2) pwr2_word <= bus.wdata;
      if (wr_ref) ref_word <= bus.wdata;
      if (wr_regc) reg_ctrl_word <= bus.wdata;
      if (wr_out) out_ctrl_word <= bus.wdata;
    end
  end

  // Unmapped and write-only offsets read as zero.
  tps_word_t rd_mux;
  always_comb begin
    unique case (bus.addr)
      `TPS_A_PWR1: rd_mux = pwr1_word;
      `TPS_A_PWR2: rd_mux = pwr2_word;
      `TPS_A_REF: rd_mux = ref_word;
      `TPS_A_REG_CTRL: rd_mux = reg_ctrl_word;
      `TPS_A_OUT_CTRL: rd_mux = out_ctrl_word;
      `TPS_A_STATUS: rd_mux = 16'(thermal_status_flag) << `TPS_B_THERMAL_STATUS_FLAG;
      default: rd_mux = 16'h0000;
    endcase
  end
  always_ff @(posedge bus.clk or negedge rst_n) begin
    if (!rst_n) bus.rdata <= 16'h0000;
    else if (bus.rd) bus.rdata <= rd_mux;
    else bus.rdata <= 16'h0000;
  end

  // ----------------------------------------
  // Thermal shutdown
  // ----------------------------------------
  // overtemp kills speakers while shutdown enable is set
  wire kill = thermal_status_flag & out_ctrl_word[`TPS_B_SHUTDOWN_EN];
  // A speaker needs its stage, its supply drive and its supply domain.
  wire r_want = pwr2_word[`TPS_B_R_STAGE] & pwr2_word[`TPS_B_R_DRIVE];
  wire l_want = pwr2_word[`TPS_B_L_STAGE] & pwr2_word[`TPS_B_L_DRIVE];
  logic temp_last_reg;
  always_ff @(posedge bus.clk or negedge rst_n) begin
    if (!rst_n) begin
      spk_r_on <= 1'b0;
      spk_l_on <= 1'b0;
      thermal_gpio <= 1'b0;
      thermal_event <= 1'b0;
      temp_last_reg <= 1'b0;
    end else begin
      spk_r_on <= r_want & !kill & spk_por_n;
      spk_l_on <= l_want & !kill & spk_por_n;
      thermal_gpio <= thermal_status_flag;
      thermal_event <= thermal_status_flag ^ temp_last_reg;
      temp_last_reg <= thermal_status_flag;
    end
  end
endmodule

// ---- bench/tps_ctrl_assertions.sv ----
// Purpose: Watches the control port for the bring-up write order.
// Assumes: Wait lengths in cycles match the host instance.
// Notes: Only the shared port is seen; device words are judged elsewhere.
`timescale 1ns/10ps
`include "tps_map.svh"
module tps_ctrl_assertions #(
  parameter int WAIT_REG_CYC = 20,
  parameter int WAIT_MID_CYC = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr,
  input wire logic rd,
  input wire tps_pkg::tps_addr_t addr,
  input wire tps_pkg::tps_word_t wdata,
  input wire tps_pkg::tps_word_t rdata,
  input wire logic por_n
);
  import tps_pkg::*;
  // ------------
  // Helpers
  // ------------
  localparam int TPOR = `TPS_TPOR_CYC;
  localparam int REG_HI = WAIT_REG_CYC + 8;
  logic [31:0] idle_reg;
  logic [31:0] low_reg;
  logic seen_reg;
  tps_word_t pwr2_reg;
  wire logic wr_soft = wr && addr == 8'h00;
  wire logic wr_pwr1 = wr && addr == 8'h02;
  wire logic wr_pwr2 = wr && addr == 8'h03;
  wire logic wr_ref = wr && addr == 8'h07;
  wire logic wr_out = wr && addr == 8'h2a;
  wire logic wr_regc = wr && addr == 8'h35;
  // Tracking restarts with the device reset, since a dropped supply
  // clears the device and the host must begin its sequence again.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_reg <= '0;
      low_reg <= '0;
      seen_reg <= 1'b0;
      pwr2_reg <= '0;
    end else begin
      idle_reg <= wr ? '0 : idle_reg + 32'd1;
      low_reg <= por_n ? '0 : low_reg + 32'd1;
      seen_reg <= por_n & (seen_reg | wr);
      // A soft reset write clears the device's copy as well.
      pwr2_reg <= (!por_n || wr_soft) ? '0 : (wr_pwr2 ? wdata : pwr2_reg);
    end
  end
  // ------------
  // Properties
  // ------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  reset_len_a: assert property ($rose(por_n) |-> low_reg >= TPOR)
    else $error("device reset released too early");
  hold_off_a: assert property (!por_n [*3] |-> !wr)
    else $error("write sent while device held in reset");
  soft_first_a: assert property (wr && !seen_reg |-> wr_soft)
    else $error("first write is not the soft reset");
  discharge_a: assert property (wr_soft |=>
    wr_out && wdata == 16'h80d0)
    else $error("discharge write does not follow soft reset");
  mid_connect_a: assert property (wr_out && wdata == 16'h80d0 |=>
    (wr_out && wdata == 16'hb4d0) ##1 (wr_ref && wdata == 16'h09a0))
    else $error("midrail connect or reference start out of order");
  reg_wait_a: assert property (wr_pwr1 && wdata == 16'h000f |->
    idle_reg >= WAIT_REG_CYC)
    else $error("regulator settle wait cut short");
  reg_bound_a: assert property (wr_regc && wdata[5] |->
    ##[1:REG_HI] (wr_pwr1 && wdata == 16'h000f))
    else $error("bias enable did not follow regulator wait");
  disch_off_a: assert property (wr_pwr1 && wdata == 16'h000f |=>
    (wr_out && wdata == 16'hb400) ##1 (wr_pwr2 && wdata == 16'h000f))
    else $error("discharge release or mixer enable out of order");
  drive_after_a: assert property (wr_pwr2 |->
    (wdata[11:10] & ~pwr2_reg[7:6]) == 2'b00)
    else $error("speaker supply drive enabled before its stage");
  mid_wait_a: assert property (wr_regc && wdata == 16'h8000 |->
    idle_reg >= WAIT_MID_CYC)
    else $error("midrail settle wait cut short");
  normal_a: assert property (wr_regc && wdata == 16'h8000 |=>
    (wr_ref && wdata == 16'h00b0) ##1 (wr_pwr1 && wdata == 16'h000d))
    else $error("normal operation settings out of order");
  read_idle_a: assert property (!rd |=> rdata == 16'h0000)
    else $error("read data not zero outside a read");
endmodule

// ---- bench/thermal_por_powerup_seq_bench.sv ----
// Purpose: Runs host and device end to end, plus a directly driven device.
// Assumes: Waits shortened to 20 and 10 cycles.
// Notes: The second device takes writes the host would never send.
`timescale 1ns/10ps
`include "tps_map.svh"
module thermal_por_powerup_seq_bench;
  import tps_pkg::*;
  // ------------
  // Harness
  // ------------
  logic clk, rst_n, ldo_ok, core_ok, io_ok, spk_ok, hot, ldo2_ok;
  logic sw_wr, sw_rd, spk_r, spk_l, tgpio, tev, io_por_n, spk_por_n, spk2_r;
  logic [3:0] sw_addr;
  tps_word_t sw_wdata, sw_rdata, pwr1, pwr2, ref_w, regc, outc, rd_val;
  int err_count, check_count, cyc, n;
  tps_ctrl_if bus (.clk(clk));
  tps_ctrl_if bus2 (.clk(clk));
  tps_host #(.WAIT_REG_CYC(20), .WAIT_MID_CYC(10)) i_tps_host (.clk(clk),
    .rst_n(rst_n), .bus(bus.host), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  tps_device i_tps_device (.rst_n(rst_n), .bus(bus.dev),
    .regulator_supply_ok(ldo_ok), .core_supply_ok(core_ok),
    .digital_io_supply_ok(io_ok), .speaker_supply_ok(spk_ok),
    .overtemp(hot), .pwr1_word(pwr1), .pwr2_word(pwr2), .ref_word(ref_w),
    .reg_ctrl_word(regc), .out_ctrl_word(outc), .spk_r_on(spk_r),
    .spk_l_on(spk_l), .thermal_gpio(tgpio), .thermal_event(tev),
    .io_por_n(io_por_n), .spk_por_n(spk_por_n));
  tps_device i_tps_device_b (.rst_n(rst_n), .bus(bus2.dev),
    .regulator_supply_ok(ldo2_ok), .core_supply_ok(core_ok),
    .digital_io_supply_ok(io_ok), .speaker_supply_ok(spk_ok),
    .overtemp(hot), .pwr1_word(), .pwr2_word(), .ref_word(),
    .reg_ctrl_word(), .out_ctrl_word(), .spk_r_on(spk2_r), .spk_l_on(),
    .thermal_gpio(), .thermal_event(), .io_por_n(), .spk_por_n());
  tps_ctrl_assertions #(.WAIT_REG_CYC(20), .WAIT_MID_CYC(10))
    i_tps_ctrl_assertions (.clk(clk), .rst_n(rst_n), .wr(bus.wr),
    .rd(bus.rd), .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata),
    .por_n(bus.por_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (err_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One port cycle: d2 picks the second device, r picks a read.
  task automatic acc(input bit d2, r, input tps_addr_t a, input tps_word_t v);
    @(posedge clk);
    if (d2) begin
      bus2.wr <= !r;
      bus2.rd <= r;
      bus2.addr <= a;
      bus2.wdata <= v;
    end else begin
      sw_wr <= !r;
      sw_rd <= r;
      sw_addr <= a[3:0];
      sw_wdata <= v;
    end
    @(posedge clk);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
    bus2.wr <= 1'b0;
    bus2.rd <= 1'b0;
    #1 rd_val = d2 ? bus2.rdata : sw_rdata;
  endtask
  task automatic wait_done();
    n = 0;
    rd_val = '0;
    while (rd_val[1] !== 1'b1 && n < 3000) begin
      acc(0, 1, 8'h01, 16'h0000);
      n++;
    end
  endtask
  // ------------
  // Scenarios
  // ------------
  task automatic t_por();
    chk("out_ctrl default", outc, 16'h8000);
    chk("pwr2 default", pwr2, 16'h0000);
    n = 0;
    while (bus.por_n !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk("reset period", n >= `TPS_TPOR_CYC, 1'b1);
    chk("domain resets", {io_por_n, spk_por_n}, 2'b11);
  endtask
  task automatic t_seq();
    acc(0, 0, 8'h00, 16'h000f);
    wait_done();
    chk("host status", rd_val[2:0], 3'b110);
    acc(0, 1, 8'h00, 16'h0000);
    chk("host options", rd_val, 16'h000e);
    chk("pwr1", pwr1, 16'h000d);
    chk("pwr2", pwr2, 16'hfccf);
    chk("ref", ref_w, 16'h00b0);
    chk("regulator", regc, 16'h8000);
    chk("out_ctrl", outc, 16'hb400);
    chk("speakers", {spk_r, spk_l}, 2'b11);
  endtask
  // A core supply dip during the midrail wait must restart bring-up.
  task automatic t_restart();
    acc(0, 0, 8'h00, 16'h0009);
    n = 0;
    while (!(bus.wr === 1'b1 && bus.wdata === 16'h09b0) && n < 3000) begin
      @(posedge clk);
      n++;
    end
    core_ok <= 1'b0;
    repeat (6) @(posedge clk);
    chk("reset on dip", bus.por_n, 1'b0);
    chk("regs cleared", pwr2, 16'h0000);
    core_ok <= 1'b1;
    wait_done();
    chk("pwr2 speakers only", pwr2, 16'h3ccf);
    chk("ref normal", ref_w, 16'h00b0);
  endtask
  task automatic t_dev2();
    acc(1, 0, 8'h03, 16'h0cc0);
    chk("low regulator holds reset", bus2.por_n, 1'b0);
    @(posedge clk);
    ldo2_ok <= 1'b1;
    n = 0;
    while (bus2.por_n !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    acc(1, 1, 8'h03, 16'h0000);
    chk("write in reset dropped", rd_val, 16'h0000);
    acc(1, 1, 8'h2a, 16'h0000);
    chk("shutdown enable default", rd_val, 16'h8000);
    acc(1, 0, 8'h2a, 16'h0000);
    acc(1, 0, 8'h03, 16'h0cc0);
    @(posedge clk);
    hot <= 1'b1;
    repeat (8) @(posedge clk);
    chk("no shutdown when off", spk2_r, 1'b1);
    hot <= 1'b0;
    acc(1, 0, 8'h00, 16'h0000);
    acc(1, 1, 8'h2a, 16'h0000);
    chk("soft reset", rd_val, 16'h8000);
    acc(1, 1, 8'h12, 16'h0000);
    chk("unmapped read", rd_val, 16'h0000);
  endtask
  task automatic t_thermal();
    @(posedge clk);
    hot <= 1'b1;
    n = 0;
    repeat (8) begin
      @(posedge clk);
      n += int'(tev);
    end
    chk("gpio hot", tgpio, 1'b1);
    chk("one event", n, 1);
    chk("speakers shut", {spk_r, spk_l}, 2'b00);
    acc(1, 1, 8'h11, 16'h0000);
    chk("status hot", rd_val, 16'h8000);
    @(posedge clk);
    hot <= 1'b0;
    repeat (8) @(posedge clk);
    chk("speakers back", {spk_r, spk_l}, 2'b11);
    acc(1, 1, 8'h11, 16'h0000);
    chk("status cool", rd_val, 16'h0000);
    @(posedge clk);
    spk_ok <= 1'b0;
    io_ok <= 1'b0;
    repeat (8) @(posedge clk);
    chk("domain drop", {io_por_n, spk_por_n, spk_r}, 3'b000);
    spk_ok <= 1'b1;
    io_ok <= 1'b1;
  endtask
  initial begin
    rst_n = 1'b0;
    {ldo_ok, core_ok, io_ok, spk_ok} = 4'hf;
    {hot, ldo2_ok, sw_wr, sw_rd} = 4'h0;
    sw_addr = 4'h0;
    sw_wdata = 16'h0000;
    {bus2.wr, bus2.rd} = 2'b00;
    bus2.addr = 8'h00;
    bus2.wdata = 16'h0000;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_por();
    t_seq();
    t_restart();
    t_dev2();
    t_thermal();
    wrap_up();
  end
  // The whole run needs about 3500 cycles; the ceiling leaves room.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end
endmodule
